// *** hw/cpu_exc_pkg.sv ***
package cpu_exc_pkg;

    // fixed vector locations, low byte at the even address
    localparam logic [15:0] VEC_NMI = 16'hFFFA;
    localparam logic [15:0] VEC_RST = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ = 16'hFFFE;

    // stack lives in page one
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h04;

    // status bit positions
    localparam int FLAG_I = 2;
    localparam int FLAG_B = 4;
    localparam int FLAG_V = 6;

    // idle cycles after the reset line rises
    localparam logic [2:0] RST_INIT_CYCLES = 3'h6;

    typedef enum logic [1:0] {
        CMD_OPFETCH,
        CMD_OPERAND,
        CMD_RESOLVE,
        CMD_ACCESS
    } cmd_op_t;

    typedef enum logic [3:0] {
        AM_IMM,
        AM_ABS,
        AM_ZP,
        AM_ZPX,
        AM_ZPY,
        AM_ABSX,
        AM_ABSY,
        AM_REL,
        AM_INDX,
        AM_INDY,
        AM_IND
    } amode_t;

    typedef struct packed {
        cmd_op_t op;
        amode_t mode;
        logic write;
        logic [7:0] op2;
        logic [7:0] op3;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [7:0] data;
    } rsp_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wdata_oe;
        logic rw;
        logic sync;
    } bus_t;

    // page-zero sum, the carry is dropped
    function automatic logic [7:0] zp_add(input logic [7:0] a, input logic [7:0] b);
        zp_add = 8'(a + b);
    endfunction : zp_add

    // 16-bit base plus 8-bit index, signed or unsigned
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [7:0] b,
                                          input logic sgn);
        logic [15:0] ext;
        ext = {{8{sgn & b[7]}}, b};
        add16 = 16'(a + ext);
    endfunction : add16

endpackage : cpu_exc_pkg

// *** hw/fall_catch.sv ***
`timescale 1ns/1ps

// sticky request raised by a falling edge of an active-low input
module fall_catch (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin_n,
    input wire logic clear,
    output logic pend
);
    logic prev_reg;
    logic pend_reg;
    wire logic fall = prev_reg & ~pin_n;
    // a new edge in the clearing cycle is kept
    wire logic pend_next = fall | (pend_reg & ~clear);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
            pend_reg <= 1'b0;
        end else begin
            prev_reg <= pin_n;
            pend_reg <= pend_next;
        end
    end

    assign pend = pend_reg;
endmodule : fall_catch

// *** hw/ea_calc.sv ***
`timescale 1ns/1ps

// effective-address arithmetic for every addressing mode
module ea_calc (
    input cpu_exc_pkg::cmd_t cmd,
    input wire logic [15:0] pc,
    input wire logic [7:0] ptr_lo,
    input wire logic [7:0] ptr_hi,
    output logic [15:0] ea_direct,
    output logic [15:0] ptr_addr,
    output logic [15:0] ptr_next,
    output logic [15:0] ea_ind,
    output logic [15:0] branch_pc
);
    wire logic [15:0] base = {cmd.op3, cmd.op2};
    wire logic [7:0] zx = cpu_exc_pkg::zp_add(cmd.op2, cmd.x);
    wire logic [7:0] zy = cpu_exc_pkg::zp_add(cmd.op2, cmd.y);
    wire logic is_ind = cmd.mode == cpu_exc_pkg::AM_IND;

    // direct modes need no memory read
    assign ea_direct =
        (cmd.mode == cpu_exc_pkg::AM_ABS)  ? base :
        (cmd.mode == cpu_exc_pkg::AM_ZP)   ? {8'h00, cmd.op2} :
        (cmd.mode == cpu_exc_pkg::AM_ZPX)  ? {8'h00, zx} :
        (cmd.mode == cpu_exc_pkg::AM_ZPY)  ? {8'h00, zy} :
        (cmd.mode == cpu_exc_pkg::AM_ABSX) ? cpu_exc_pkg::add16(base, cmd.x, 1'b0) :
        (cmd.mode == cpu_exc_pkg::AM_ABSY) ? cpu_exc_pkg::add16(base, cmd.y, 1'b0) :
        16'h0000;

    // pointer location and its successor; page-zero pointers wrap in page zero
    assign ptr_addr =
        (cmd.mode == cpu_exc_pkg::AM_INDX) ? {8'h00, zx} :
        is_ind ? base : {8'h00, cmd.op2};
    assign ptr_next = is_ind ? cpu_exc_pkg::add16(ptr_addr, 8'h01, 1'b0)
                             : {8'h00, cpu_exc_pkg::zp_add(ptr_addr[7:0], 8'h01)};

    // only the post-indexed form adds after the pointer read
    assign ea_ind = (cmd.mode == cpu_exc_pkg::AM_INDY)
                  ? cpu_exc_pkg::add16({ptr_hi, ptr_lo}, cmd.y, 1'b0)
                  : {ptr_hi, ptr_lo};

    // pc already points at the next instruction
    assign branch_pc = cpu_exc_pkg::add16(pc, cmd.op2, 1'b1);
endmodule : ea_calc

// *** hw/cpu_exc_unit.sv ***
`timescale 1ns/1ps

// Overview of operation
// - finish instruction before taking maskable request
// - maskable request taken only with mask clear
// - push pc and status, then set mask
// - maskable vector low FFFE, high FFFF
// - non-maskable input is falling-edge triggered
// - non-maskable ignores mask, vector FFFA/FFFB
// - sample interrupts, enter after instruction completes
// - set-overflow falling edge sets overflow bit
// - sync high through each opcode fetch cycle
// - ready low in sync cycle freezes processor
// - no writes in reset; rising edge starts sequence
// - six idle cycles, set mask, vector FFFC/FFFD
// - direction high for reads, low for writes
// - immediate, absolute and zero-page address forming
// - zero-page indexed sums wrap in page zero
// - absolute indexed adds index to 16-bit base
// - branch adds signed offset to next pc
// - indexed-indirect pointer in page zero, no carry
// - indirect-indexed adds y with carry to pointer
// - absolute-indirect loads pointer target into pc
module cpu_exc_unit (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cpu_reset_n,
    input wire logic irq_n,
    input wire logic nmi_n,
    input wire logic so_n,
    input wire logic rdy,
    input wire logic [7:0] bus_rdata,
    output cpu_exc_pkg::bus_t bus_o,
    input wire logic cmd_valid,
    input cpu_exc_pkg::cmd_t cmd_i,
    output logic cmd_ready,
    output logic rsp_valid,
    output cpu_exc_pkg::rsp_t rsp_o,
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    input wire logic sp_wr,
    input wire logic [7:0] sp_wdata,
    output logic [7:0] status,
    output logic [7:0] sp,
    output logic [15:0] pc
);
    typedef enum logic [3:0] {
        ST_HOLD,
        ST_INIT,
        ST_VL,
        ST_VH,
        ST_IDLE,
        ST_PCRD,
        ST_PSH_H,
        ST_PSH_L,
        ST_PSH_P,
        ST_PTRL,
        ST_PTRH,
        ST_ACC
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [15:0] pc_reg;
    logic [7:0] sp_reg;
    logic [7:0] status_reg;
    logic [15:0] vec_reg;
    logic [2:0] cnt_reg;
    logic irq_s_reg;
    logic sync_reg;
    logic [7:0] ptr_lo_reg;
    cpu_exc_pkg::cmd_t cmd_reg;
    cpu_exc_pkg::rsp_t rsp_reg;
    logic rsp_valid_reg;
    logic nmi_pend;
    logic so_fall;
    logic [15:0] ea_direct;
    logic [15:0] ptr_addr;
    logic [15:0] ptr_next;
    logic [15:0] ea_ind;
    logic [15:0] branch_pc;

    // state decode
    wire logic in_idle = state_reg == ST_IDLE;
    wire logic in_push = (state_reg == ST_PSH_H) | (state_reg == ST_PSH_L)
                       | (state_reg == ST_PSH_P);
    wire logic acc_wr = (state_reg == ST_ACC) & cmd_reg.write;

    // the command in flight: the incoming one while idle, else the latched one
    wire cpu_exc_pkg::cmd_t cmd_sel = in_idle ? cmd_i : cmd_reg;
    wire logic is_fetch = cmd_i.op == cpu_exc_pkg::CMD_OPFETCH;
    wire logic is_resolve = cmd_i.op == cpu_exc_pkg::CMD_RESOLVE;
    wire logic is_ptr_mode = (cmd_i.mode == cpu_exc_pkg::AM_INDX)
                           | (cmd_i.mode == cpu_exc_pkg::AM_INDY)
                           | (cmd_i.mode == cpu_exc_pkg::AM_IND);

    // an opcode fetch request marks the end of the previous instruction,
    // so pending interrupts are only examined there
    wire logic irq_ok = ~irq_s_reg & ~status_reg[cpu_exc_pkg::FLAG_I];
    wire logic int_take = nmi_pend | irq_ok;
    wire logic int_start = in_idle & cmd_valid & is_fetch & int_take;
    wire logic accept = in_idle & cmd_valid & ~int_take | (in_idle & cmd_valid & ~is_fetch);

    // direction: only the push and store cycles drive the bus, and none while the
    // reset pin is low, since the state only follows that pin one edge later
    wire logic rw_w = ~((in_push | acc_wr) & cpu_reset_n);
    // ready stalls read cycles only; a write always completes
    wire logic adv = ~rw_w | rdy;

    assign cmd_ready = in_idle & ~(is_fetch & int_take);

    // bus address for each cycle
    assign bus_o.addr =
        (state_reg == ST_VL)   ? vec_reg :
        (state_reg == ST_VH)   ? {vec_reg[15:1], 1'b1} :
        in_push                ? {cpu_exc_pkg::STACK_PAGE, sp_reg} :
        (state_reg == ST_PTRL) ? ptr_addr :
        (state_reg == ST_PTRH) ? ptr_next :
        (state_reg == ST_ACC)  ? {cmd_reg.op3, cmd_reg.op2} :
        pc_reg;

    // pushed status carries the break bit clear for hardware entry
    assign bus_o.wdata =
        (state_reg == ST_PSH_H) ? pc_reg[15:8] :
        (state_reg == ST_PSH_L) ? pc_reg[7:0] :
        (state_reg == ST_PSH_P) ? (status_reg & ~(8'h01 << cpu_exc_pkg::FLAG_B)) :
        acc_wr                  ? cmd_reg.wdata :
        8'h00;
    assign bus_o.wdata_oe = ~rw_w;
    assign bus_o.rw = rw_w;
    assign bus_o.sync = (state_reg == ST_PCRD) & sync_reg;

    // leaf blocks
    fall_catch u_nmi (
        .clock(clock),
        .rst_n(rst_n),
        .pin_n(nmi_n),
        .clear(int_start),
        .pend(nmi_pend)
    );

    // the overflow request lasts one cycle only
    fall_catch u_so (
        .clock(clock),
        .rst_n(rst_n),
        .pin_n(so_n),
        .clear(1'b1),
        .pend(so_fall)
    );

    ea_calc u_ea (
        .cmd(cmd_sel),
        .pc(pc_reg),
        .ptr_lo(ptr_lo_reg),
        .ptr_hi(bus_rdata),
        .ea_direct(ea_direct),
        .ptr_addr(ptr_addr),
        .ptr_next(ptr_next),
        .ea_ind(ea_ind),
        .branch_pc(branch_pc)
    );

    // next state; the reset line overrides everything
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_HOLD: state_next = ST_INIT;
            ST_INIT: begin
                if (cnt_reg == 3'(cpu_exc_pkg::RST_INIT_CYCLES - 3'h1)) begin
                    state_next = ST_VL;
                end
            end
            ST_VL: if (adv) state_next = ST_VH;
            ST_VH: if (adv) state_next = ST_IDLE;
            ST_IDLE: begin
                if (int_start) begin
                    state_next = ST_PSH_H;
                end else if (cmd_valid) begin
                    unique case (cmd_i.op)
                        cpu_exc_pkg::CMD_OPFETCH: state_next = ST_PCRD;
                        cpu_exc_pkg::CMD_OPERAND: state_next = ST_PCRD;
                        cpu_exc_pkg::CMD_RESOLVE: begin
                            if (is_ptr_mode) state_next = ST_PTRL;
                        end
                        cpu_exc_pkg::CMD_ACCESS: state_next = ST_ACC;
                    endcase
                end
            end
            ST_PCRD: if (adv) state_next = ST_IDLE;
            ST_PSH_H: state_next = ST_PSH_L;
            ST_PSH_L: state_next = ST_PSH_P;
            ST_PSH_P: state_next = ST_VL;
            ST_PTRL: if (adv) state_next = ST_PTRH;
            ST_PTRH: if (adv) state_next = ST_IDLE;
            ST_ACC: if (adv) state_next = ST_IDLE;
        endcase
        if (!cpu_reset_n) begin
            state_next = ST_HOLD;
        end
    end

    // status: core write, then hardware sets win over it
    wire logic set_i = (state_reg == ST_PSH_P) | (state_reg == ST_INIT & state_next == ST_VL);
    wire logic [7:0] status_base = status_wr ? status_wdata : status_reg;
    wire logic [7:0] status_next = status_base
        | ({7'h00, so_fall} << cpu_exc_pkg::FLAG_V)
        | ({7'h00, set_i} << cpu_exc_pkg::FLAG_I);

    // pc updates
    wire logic resolve_now = accept & is_resolve;
    wire logic [15:0] pc_next =
        (state_reg == ST_VL & adv) ? {pc_reg[15:8], bus_rdata} :
        (state_reg == ST_VH & adv) ? {bus_rdata, pc_reg[7:0]} :
        (state_reg == ST_PCRD & adv) ? cpu_exc_pkg::add16(pc_reg, 8'h01, 1'b0) :
        (resolve_now & cmd_i.mode == cpu_exc_pkg::AM_REL) ? branch_pc :
        (state_reg == ST_PTRH & adv & cmd_reg.mode == cpu_exc_pkg::AM_IND) ? ea_ind :
        pc_reg;

    wire logic [7:0] sp_next = in_push ? 8'(sp_reg - 8'h01) : sp_wr ? sp_wdata : sp_reg;

    // one answer per completed command
    wire logic rsp_direct = resolve_now & ~is_ptr_mode;
    wire logic rsp_fire = rsp_direct | (state_reg == ST_PCRD & adv)
                        | (state_reg == ST_PTRH & adv) | (state_reg == ST_ACC & adv);
    wire cpu_exc_pkg::rsp_t rsp_next =
        rsp_direct ? {(cmd_i.mode == cpu_exc_pkg::AM_REL) ? branch_pc : ea_direct,
                      cmd_i.op2} :
        (state_reg == ST_PTRH) ? {ea_ind, 8'h00} :
        {bus_o.addr, rw_w ? bus_rdata : 8'h00};

    // vector choice: non-maskable beats maskable
    wire logic [15:0] vec_next = (state_reg == ST_HOLD) ? cpu_exc_pkg::VEC_RST :
        int_start ? (nmi_pend ? cpu_exc_pkg::VEC_NMI : cpu_exc_pkg::VEC_IRQ) : vec_reg;

    // fsm and reset-sequence counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_HOLD;
            cnt_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= (state_reg == ST_INIT) ? 3'(cnt_reg + 3'h1) : 3'h0;
        end
    end

    // architectural registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= 16'h0000;
            sp_reg <= cpu_exc_pkg::SP_RESET;
            status_reg <= cpu_exc_pkg::STATUS_RESET;
            vec_reg <= cpu_exc_pkg::VEC_RST;
        end else begin
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            status_reg <= status_next;
            vec_reg <= vec_next;
        end
    end

    // level sample of the maskable line, once per cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_s_reg <= 1'b1;
        end else begin
            irq_s_reg <= irq_n;
        end
    end

    // command capture and pointer low byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
            sync_reg <= 1'b0;
            ptr_lo_reg <= 8'h00;
        end else begin
            if (accept) cmd_reg <= cmd_i;
            if (accept) sync_reg <= is_fetch;
            if (state_reg == ST_PTRL & adv) ptr_lo_reg <= bus_rdata;
        end
    end

    // registered answer, valid for one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_reg <= '0;
        end else begin
            rsp_valid_reg <= rsp_fire;
            if (rsp_fire) rsp_reg <= rsp_next;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_o = rsp_reg;
    assign status = status_reg;
    assign sp = sp_reg;
    assign pc = pc_reg;
endmodule : cpu_exc_unit

// *** tb/cpu_mem_model.sv ***
`timescale 1ns/1ps

// flat 64K memory seen across the parallel bus, answers in the same cycle
module cpu_mem_model (
    input wire logic clock,
    input cpu_exc_pkg::bus_t bus_i,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg;

    // preset contents so no read returns an unknown
    initial begin
        last_reg = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i[7:0] ^ i[15:8]);
        end
    end

    // outside reads the lines toggle, so a stale byte is never mistaken for data
    assign rdata = bus_i.rw ? mem[bus_i.addr] : ~last_reg;

    // writes land at the edge that ends the write cycle
    always @(posedge clock) begin
        last_reg <= rdata;
        if (!bus_i.rw && bus_i.wdata_oe) begin
            mem[bus_i.addr] <= bus_i.wdata;
        end
    end
endmodule : cpu_mem_model

// *** tb/cpu_exc_unit_sva.sv ***
`timescale 1ns/1ps

// bus-level checks on the exception unit's ports
module cpu_exc_unit_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cpu_reset_n,
    input wire logic so_n,
    input wire logic rdy,
    input wire logic [7:0] bus_rdata,
    input cpu_exc_pkg::bus_t bus_o,
    input wire logic rsp_valid,
    input cpu_exc_pkg::rsp_t rsp_o,
    input wire logic [7:0] status,
    input wire logic [7:0] sp
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // a write into page one is a stack push
    wire logic stack_wr = !bus_o.rw && bus_o.addr[15:8] == cpu_exc_pkg::STACK_PAGE;

    sequence init_idle;
        (bus_o.rw && !bus_o.sync) [*6];
    endsequence
    sequence push3;
        stack_wr [*3];
    endsequence
    sequence vec_lo;
        bus_o.rw && (bus_o.addr == 16'hFFFE || bus_o.addr == 16'hFFFA);
    endsequence

    a_no_write_reset: assert property (!cpu_reset_n |-> bus_o.rw && !bus_o.wdata_oe)
        else $error("write cycle while reset held");
    a_reset_vector: assert property ($rose(cpu_reset_n) && rdy |->
        ##1 init_idle ##1 (bus_o.rw && bus_o.addr == 16'hFFFC))
        else $error("reset vector fetch not seven cycles after release");
    a_reset_mask: assert property (bus_o.rw && bus_o.addr == 16'hFFFC && rdy && !bus_o.sync
        |=> bus_o.addr == 16'hFFFD && status[cpu_exc_pkg::FLAG_I])
        else $error("reset vector high byte or mask missing");
    a_irq_vec_pair: assert property (bus_o.rw && bus_o.addr == 16'hFFFE && rdy
        |=> bus_o.addr == 16'hFFFF)
        else $error("maskable vector high byte not next");
    a_nmi_vec_pair: assert property (bus_o.rw && bus_o.addr == 16'hFFFA && rdy
        |=> bus_o.addr == 16'hFFFB)
        else $error("non-maskable vector high byte not next");
    a_push_order: assert property ($rose(stack_wr) |->
        push3 ##[1:2] vec_lo ##1 status[cpu_exc_pkg::FLAG_I])
        else $error("entry pushes or mask out of order");
    a_push_at_sp: assert property (stack_wr |-> bus_o.addr[7:0] == sp)
        else $error("push not at stack pointer");
    a_dir_enable: assert property (bus_o.wdata_oe == !bus_o.rw)
        else $error("data drive disagrees with direction");
    a_sync_one_cycle: assert property (bus_o.sync && rdy |=> !bus_o.sync)
        else $error("sync longer than one fetch cycle");
    a_stall_freeze: assert property (bus_o.sync && !rdy
        |=> bus_o.sync && $stable(bus_o.addr) && !rsp_valid)
        else $error("fetch moved while ready low");
    a_fetch_answer: assert property (bus_o.sync && rdy |=> rsp_valid
        && rsp_o.data == $past(bus_rdata) && rsp_o.ea == $past(bus_o.addr))
        else $error("fetch answer wrong");
    a_so_sets_v: assert property ($fell(so_n) |-> ##[1:2] status[cpu_exc_pkg::FLAG_V])
        else $error("overflow bit not set");
endmodule : cpu_exc_unit_chk

bind cpu_exc_unit cpu_exc_unit_chk i_cpu_exc_unit_chk (.clock(clock), .rst_n(rst_n),
    .cpu_reset_n(cpu_reset_n), .so_n(so_n), .rdy(rdy), .bus_rdata(bus_rdata),
    .bus_o(bus_o), .rsp_valid(rsp_valid), .rsp_o(rsp_o), .status(status), .sp(sp));

// *** tb/cpu_exc_unit_tb_top.sv ***
`timescale 1ns/1ps

module cpu_exc_unit_tb_top;
    logic clock, rst_n, cpu_reset_n, irq_n, nmi_n, so_n, rdy, status_wr;
    logic cmd_valid, cmd_ready, rsp_valid;
    logic [7:0] bus_rdata, status_wdata, status, sp;
    logic [15:0] pc, p, q, e;
    cpu_exc_pkg::bus_t bus_o;
    cpu_exc_pkg::cmd_t cmd_i;
    cpu_exc_pkg::rsp_t rsp_o;
    int n_errors, compares, cyc, n1;
    // vectors and pointers placed before reset: address then byte
    localparam logic [23:0] PRE [12] = '{24'hFFFA00, 24'hFFFB04, 24'hFFFC00, 24'hFFFD02,
        24'hFFFE00, 24'hFFFF03, 24'h0010CD, 24'h0011AB, 24'h00F0F8, 24'h00F134,
        24'h12F078, 24'h12F156};

    cpu_exc_unit i_cpu_exc_unit (.clock(clock), .rst_n(rst_n), .cpu_reset_n(cpu_reset_n),
        .irq_n(irq_n), .nmi_n(nmi_n), .so_n(so_n), .rdy(rdy), .bus_rdata(bus_rdata),
        .bus_o(bus_o), .cmd_valid(cmd_valid), .cmd_i(cmd_i), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_o(rsp_o), .status_wr(status_wr),
        .status_wdata(status_wdata), .sp_wr(1'b0), .sp_wdata(8'h00), .status(status),
        .sp(sp), .pc(pc));
    cpu_mem_model i_cpu_mem_model (.clock(clock), .bus_i(bus_o), .rdata(bus_rdata));

    // 25 MHz
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic [7:0] pat(input logic [15:0] a);
        pat = a[7:0] ^ a[15:8];
    endfunction : pat

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // valid held until the answer pulses; ready dropped st cycles once sync shows
    task automatic run(input cpu_exc_pkg::cmd_op_t op, input cpu_exc_pkg::amode_t m,
                       input logic [7:0] o2, input logic [7:0] o3, input logic wr,
                       input int st);
        cmd_i = '{op, m, wr, o2, o3, 8'h20, 8'h10, 8'h5A};
        cyc = 0;
        cmd_valid = 1'b1;
        do begin
            @(negedge clock);
            cyc++;
            rdy = !(bus_o.sync && st > 0);
            if (!rdy) st--;
        end while (rsp_valid !== 1'b1 && cyc < 100);
        cmd_valid = 1'b0;
        if (cyc >= 100) begin
            chk(16'(cyc), 16'h0000);
            test_done;
        end
        @(negedge clock);
    endtask : run

    task automatic fetch(input int st);
        run(cpu_exc_pkg::CMD_OPFETCH, cpu_exc_pkg::AM_IMM, 8'h00, 8'h00, 1'b0, st);
    endtask : fetch

    task automatic t_reset;
        repeat (2) @(negedge clock); // reset pin low two cycles past power-up
        chk(16'(bus_o.rw), 16'h0001); // no write while held
        cpu_reset_n = 1'b1;
        cyc = 0;
        do begin
            @(negedge clock);
            cyc++;
        end while (cmd_ready !== 1'b1 && cyc < 50);
        chk(16'(cmd_ready), 16'h0001); // sequence ended within bound
        chk(pc, 16'h0200); // pc from reset vector
        chk(16'(status[cpu_exc_pkg::FLAG_I]), 16'h0001); // mask set
        $display("t_reset done");
    endtask : t_reset

    task automatic t_fetch;
        fetch(0);
        n1 = cyc;
        chk(rsp_o.ea, p); // fetch at pc
        chk(16'(rsp_o.data), 16'(pat(p))); // fetched byte
        p = p + 16'h0001;
        fetch(3);
        chk(16'(cyc - n1), 16'h0003); // three frozen cycles
        chk(16'(rsp_o.data), 16'(pat(p))); // data intact after freeze
        p = p + 16'h0001;
        run(cpu_exc_pkg::CMD_OPERAND, cpu_exc_pkg::AM_IMM, 8'h00, 8'h00, 1'b0, 3);
        chk(16'(cyc), 16'(n1)); // no sync on operand reads, so no stall
        chk(rsp_o.ea, p); // operand byte taken at pc
        p = p + 16'h0001;
        chk(pc, p); // pc stepped once each
        $display("t_fetch done");
    endtask : t_fetch

    task automatic t_modes;
        for (int m = 0; m < 11; m++) begin
            case (m)
                0: e = 16'h00F0; // immediate operand
                1: e = 16'h12F0; // absolute
                2: e = 16'h00F0; // zero page
                3: e = 16'h0010; // zero page x wraps
                4: e = 16'h0000; // zero page y wraps
                5: e = 16'h1310; // absolute x crosses page
                6: e = 16'h1300; // absolute y
                7: e = p + 16'hFFF0; // branch back 16
                8: e = 16'hABCD; // pointer at 10
                9: e = 16'h3508; // carry into high byte
                default: e = 16'h5678; // pointer at 12F0
            endcase
            run(cpu_exc_pkg::CMD_RESOLVE, cpu_exc_pkg::amode_t'(m[3:0]), 8'hF0, 8'h12, 1'b0, 0);
            chk(m == 0 ? 16'(rsp_o.data) : rsp_o.ea, e);
            if (m == 7 || m == 10) p = e;
        end
        chk(pc, p); // pc loaded by branch and indirect
        $display("t_modes done");
    endtask : t_modes

    task automatic t_access;
        run(cpu_exc_pkg::CMD_ACCESS, cpu_exc_pkg::AM_ABS, 8'h40, 8'h20, 1'b1, 0);
        chk(16'(i_cpu_mem_model.mem[16'h2040]), 16'h005A); // byte written out
        run(cpu_exc_pkg::CMD_ACCESS, cpu_exc_pkg::AM_ABS, 8'h40, 8'h20, 1'b0, 0);
        chk(16'(rsp_o.data), 16'h005A); // read back
        $display("t_access done");
    endtask : t_access

    task automatic t_irq;
        irq_n = 1'b0;
        fetch(0);
        chk(rsp_o.ea, p); // masked request ignored
        p = p + 16'h0001;
        status_wr = 1'b1;
        @(negedge clock);
        status_wr = 1'b0;
        run(cpu_exc_pkg::CMD_RESOLVE, cpu_exc_pkg::AM_ABS, 8'hF0, 8'h12, 1'b0, 0);
        chk(rsp_o.ea, 16'h12F0); // current work not cut short
        q = p;
        fetch(0); // ready left high; the opcode fetch request is where the pending request is taken
        irq_n = 1'b1;
        chk(rsp_o.ea, 16'h0300); // entered at boundary via vector
        chk(16'(i_cpu_mem_model.mem[16'h01FF]), 16'(q[15:8]));
        chk(16'(i_cpu_mem_model.mem[16'h01FE]), 16'(q[7:0]));
        chk(16'(i_cpu_mem_model.mem[16'h01FD]), 16'h0000); // status pushed
        chk({sp, 7'h00, status[cpu_exc_pkg::FLAG_I]}, 16'hFC01);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_nmi;
        nmi_n = 1'b0;
        @(negedge clock);
        fetch(0);
        chk(rsp_o.ea, 16'h0400); // taken despite mask
        chk(16'(sp), 16'h00F9); // three more pushes
        fetch(0);
        chk(rsp_o.ea, 16'h0401); // low level alone does not re-enter
        nmi_n = 1'b1;
        $display("t_nmi done");
    endtask : t_nmi

    task automatic t_so;
        so_n = 1'b0;
        repeat (3) @(negedge clock);
        chk(16'(status[cpu_exc_pkg::FLAG_V]), 16'h0001); // overflow set
        so_n = 1'b1;
        $display("t_so done");
    endtask : t_so

    // main sequence, inputs change on the falling edge
    initial begin
        rst_n = 1'b0;
        cpu_reset_n = 1'b0;
        irq_n = 1'b1;
        nmi_n = 1'b1;
        so_n = 1'b1;
        rdy = 1'b1;
        cmd_valid = 1'b0;
        cmd_i = '0;
        status_wr = 1'b0;
        status_wdata = 8'h00;
        n_errors = 0;
        compares = 0;
        p = 16'h0200;
        repeat (3) @(negedge clock);
        foreach (PRE[i]) i_cpu_mem_model.mem[PRE[i][23:8]] = PRE[i][7:0];
        rst_n = 1'b1;
        t_reset;
        t_fetch;
        t_modes;
        t_access;
        t_irq;
        t_nmi;
        t_so;
        // clear the mask, then pull the reset pin mid-run; it must set the mask again
        status_wr = 1'b1;
        @(negedge clock);
        status_wr = 1'b0;
        cpu_reset_n = 1'b0;
        t_reset;
        test_done;
    end
endmodule : cpu_exc_unit_tb_top
